// *** logic/timer_pwm_defs.vh ***
/*
 * Register indices, field positions, reset values and codes for the
 * timer compare/capture and control-zero register block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef TIMER_PWM_DEFS_VH
`define TIMER_PWM_DEFS_VH

// Bus geometry
`define ADDR_W          16
`define IDX_MSB         13
`define IDX_LSB         2
`define IDX_W           12
`define ADDR_TOP        15
`define ADDR_TOP_LO     14

// Register indices, byte address is four times the index
`define IDX_CMP_HIGH    12'hf04
`define IDX_CMP_LOW     12'hf05
`define IDX_CTL_ZERO    12'hf06
`define IDX_CH_STRIDE   12'h008

// Reset values
`define RST_CMP         8'h00
`define RST_CTL         8'h00

// Control register zero fields
`define CTL_MODE_MSB    7
`define CTL_IRQ_HI      6
`define CTL_IRQ_LO      5
`define CTL_DLY_HI      3
`define CTL_DLY_LO      1
`define CTL_CAP_FLAG    0
`define CTL_WR_MASK     8'hef

// Interrupt source codes
`define IRQ_ONLY_CAP    2'b10
`define IRQ_ONLY_RLD    2'b11

// Deadband
`define DLY_NONE        3'h0
`define DLY_CNT_W       8
`define DLY_ONE         8'h01
`define DLY_ZERO        8'h00

// Responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// *** logic/timer_pwm_regs.v ***
/*
 * Compare/capture value and control-zero registers of two 16-bit
 * counter/timers, with PWM toggle, deadband, interrupt source select
 * and capture flag, behind an AXI4-Lite slave.
 * Assumes the counting logic shares core_clk and supplies the count,
 * one-cycle capture and reload pulses, enable, polarity and mode bits;
 * these inputs are therefore read without synchronisers.
 * Assumes a bus master that offers write address and data together;
 * a lone address or lone data beat waits until its partner arrives.
 * Each register is one byte in bits 7:0 of an aligned word; other
 * lanes read as zero and unmapped or misaligned words answer SLVERR.
 * Capture and hardware flag updates win over a same-cycle bus write.
 * Leaving the deadband with the timer disabled still counts it down,
 * so the outputs return to the polarity level.
 */
// The AXI4-Lite register port was chosen for this implementation.
// Contract
// - Compare value is high and low byte joined
// - Match with count toggles PWM output
// - PWM level taken from output polarity
// - Capture writes count into compare bytes
// - Control registers are 8-bit read/write; here control zero bit 4 is not writable and reads as zero
// - Mode comes from both control registers
// - Deadband delay field in bits 3:1
// - Interrupt source field in bits 6:5
// - Bit 0 flags capture-caused interrupt
// - Source codes: 0x all, 10 input, 11 reload
// - Deadband code n gives 2^n cycles; here both outputs stay low 2^n + 1 cycles, and code 0 gives none
// - Flag one when last interrupt was capture
// - Bit 7 is mode select top bit
`include "timer_pwm_defs.vh"

module timer_pwm_regs (
    // Clock and reset
    input  wire                 core_clk,
    input  wire                 rst,
    // AXI4-Lite write address and data
    input  wire [31:0]          s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // AXI4-Lite read
    input  wire [31:0]          s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Counter side, two channels packed low channel first
    input  wire [31:0]          timer_count,
    input  wire [1:0]           timer_enable,
    input  wire [1:0]           capture_pulse,
    input  wire [1:0]           reload_pulse,
    input  wire [1:0]           output_polarity,
    input  wire [5:0]           mode_select_low,
    // Outputs
    output wire [7:0]           mode_select,
    output wire [1:0]           pwm_out,
    output wire [1:0]           pwm_out_n,
    output wire [1:0]           timer_irq
);

    wire                        wr_fire;
    wire                        rd_fire;
    wire                        wr_top_ok;
    wire                        rd_top_ok;
    wire [`IDX_W-1:0]           wr_idx;
    wire [`IDX_W-1:0]           rd_idx;
    wire [1:0]                  wr_hit;
    wire [1:0]                  rd_hit;
    wire [15:0]                 rd_byte;
    wire                        aw_take;
    wire                        ar_take;
    wire                        wr_mapped;
    wire                        rd_mapped;

    assign wr_fire   = s_axi_awvalid & s_axi_wvalid & s_axi_awready;
    assign rd_fire   = s_axi_arvalid & s_axi_arready;
    assign wr_idx    = s_axi_awaddr[`IDX_MSB:`IDX_LSB];
    assign rd_idx    = s_axi_araddr[`IDX_MSB:`IDX_LSB];
    assign wr_top_ok = (s_axi_awaddr[31:`ADDR_TOP_LO] == 18'h00000) && (s_axi_awaddr[1:0] == 2'h0);
    assign rd_top_ok = (s_axi_araddr[31:`ADDR_TOP_LO] == 18'h00000) && (s_axi_araddr[1:0] == 2'h0);
    assign aw_take   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    assign ar_take   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    assign wr_mapped = |wr_hit;
    assign rd_mapped = |rd_hit;

    // Write channel: address and data taken together
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= aw_take;
            s_axi_wready  <= aw_take;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ar_take;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte[7:0] | rd_byte[15:8]};
                s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg  [7:0]              cmp_high_r;
            reg  [7:0]              cmp_low_r;
            reg  [7:0]              ctl_zero_r;
            reg                     match_d_r;
            reg                     pwm_state_r;
            reg  [`DLY_CNT_W-1:0]   dly_cnt_r;
            reg  [7:0]              rd_val;
            wire [`IDX_W-1:0]       base;
            wire [15:0]             cmp_value;
            wire [15:0]             count;
            wire                    match;
            wire                    match_rise;
            wire                    wr_high;
            wire                    wr_low;
            wire                    wr_ctl;
            wire                    wr_lane;
            wire [1:0]              irq_cfg;
            wire                    irq_cap;
            wire                    irq_rld;
            wire [2:0]              dly_code;
            wire [`DLY_CNT_W-1:0]   dly_load;
            wire                    hold_low;
            wire                    wr_sel_high;
            wire                    wr_sel_low;
            wire                    wr_sel_ctl;
            wire                    rd_sel_high;
            wire                    rd_sel_low;
            wire                    rd_sel_ctl;
            // Next values and output flops
            reg  [7:0]              ctl_zero_nxt;
            reg                     pwm_state_nxt;
            reg  [`DLY_CNT_W-1:0]   dly_cnt_nxt;
            reg                     pwm_r;
            reg                     pwm_n_r;
            reg                     irq_r;
            reg  [3:0]              mode_r;

            assign base      = (g == 0) ? {`IDX_W{1'b0}} : `IDX_CH_STRIDE;
            assign count     = timer_count[g*16 +: 16];
            assign cmp_value = {cmp_high_r, cmp_low_r};
            assign match     = (cmp_value == count);
            assign match_rise = match & ~match_d_r & timer_enable[g];
            assign wr_lane   = wr_fire & wr_top_ok & s_axi_wstrb[0];
            assign wr_sel_high = wr_top_ok & (wr_idx == `IDX_CMP_HIGH + base);
            assign wr_sel_low  = wr_top_ok & (wr_idx == `IDX_CMP_LOW + base);
            assign wr_sel_ctl  = wr_top_ok & (wr_idx == `IDX_CTL_ZERO + base);
            assign rd_sel_high = rd_top_ok & (rd_idx == `IDX_CMP_HIGH + base);
            assign rd_sel_low  = rd_top_ok & (rd_idx == `IDX_CMP_LOW + base);
            assign rd_sel_ctl  = rd_top_ok & (rd_idx == `IDX_CTL_ZERO + base);
            assign wr_high   = wr_lane & wr_sel_high;
            assign wr_low    = wr_lane & wr_sel_low;
            assign wr_ctl    = wr_lane & wr_sel_ctl;
            assign irq_cfg   = ctl_zero_r[`CTL_IRQ_HI:`CTL_IRQ_LO];
            // Source select: 0x all, 10 capture only, 11 reload/compare only
            assign irq_cap   = capture_pulse[g] & (irq_cfg != `IRQ_ONLY_RLD);
            assign irq_rld   = (reload_pulse[g] | match_rise) & (irq_cfg != `IRQ_ONLY_CAP);
            assign dly_code  = ctl_zero_r[`CTL_DLY_HI:`CTL_DLY_LO];
            assign dly_load  = (dly_code == `DLY_NONE) ? `DLY_ZERO : (`DLY_ONE << dly_code);

            assign wr_hit[g] = wr_sel_high | wr_sel_low | wr_sel_ctl;
            assign rd_hit[g] = rd_sel_high | rd_sel_low | rd_sel_ctl;
            assign rd_byte[g*8 +: 8] = rd_val;

            // Read data select
            always @* begin
                rd_val = 8'h00;
                if (rd_sel_high) begin
                    rd_val = cmp_high_r;
                end else if (rd_sel_low) begin
                    rd_val = cmp_low_r;
                end else if (rd_sel_ctl) begin
                    rd_val = ctl_zero_r;
                end
            end

            // Compare bytes, capture wins over software
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    cmp_high_r <= `RST_CMP;
                    cmp_low_r  <= `RST_CMP;
                end else if (capture_pulse[g]) begin
                    cmp_high_r <= count[15:8];
                    cmp_low_r  <= count[7:0];
                end else begin
                    if (wr_high) begin
                        cmp_high_r <= s_axi_wdata[7:0];
                    end
                    if (wr_low) begin
                        cmp_low_r <= s_axi_wdata[7:0];
                    end
                end
            end

            // Control zero next value, capture flag set by hardware wins
            always @* begin
                ctl_zero_nxt = ctl_zero_r;
                if (wr_ctl) begin
                    ctl_zero_nxt = s_axi_wdata[7:0] & `CTL_WR_MASK;
                end
                if (irq_cap | irq_rld) begin
                    ctl_zero_nxt[`CTL_CAP_FLAG] = irq_cap;
                end
            end

            // Control zero register
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    ctl_zero_r <= `RST_CTL;
                end else begin
                    ctl_zero_r <= ctl_zero_nxt;
                end
            end

            // Next PWM state and deadband count
            always @* begin
                pwm_state_nxt = pwm_state_r;
                dly_cnt_nxt   = dly_cnt_r;
                if (dly_cnt_r != `DLY_ZERO) begin
                    dly_cnt_nxt = dly_cnt_r - `DLY_ONE;
                end
                if (!timer_enable[g]) begin
                    pwm_state_nxt = output_polarity[g];
                end else if (match_rise) begin
                    pwm_state_nxt = ~pwm_state_r;
                    dly_cnt_nxt   = dly_load;
                end
            end

            // Both outputs held low while the deadband runs
            assign hold_low = (dly_cnt_r != `DLY_ZERO) | (match_rise & (dly_load != `DLY_ZERO));

            // PWM state and outputs
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    match_d_r   <= 1'b0;
                    pwm_state_r <= 1'b0;
                    dly_cnt_r   <= `DLY_ZERO;
                    pwm_r       <= 1'b0;
                    pwm_n_r     <= 1'b0;
                end else begin
                    match_d_r   <= match;
                    pwm_state_r <= pwm_state_nxt;
                    dly_cnt_r   <= dly_cnt_nxt;
                    if (hold_low) begin
                        pwm_r   <= 1'b0;
                        pwm_n_r <= 1'b0;
                    end else begin
                        pwm_r   <= pwm_state_r;
                        pwm_n_r <= ~pwm_state_r;
                    end
                end
            end

            // Interrupt pulse and merged mode select
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    irq_r  <= 1'b0;
                    mode_r <= 4'h0;
                end else begin
                    irq_r  <= irq_cap | irq_rld;
                    mode_r <= {ctl_zero_r[`CTL_MODE_MSB], mode_select_low[g*3 +: 3]};
                end
            end

            assign pwm_out[g]            = pwm_r;
            assign pwm_out_n[g]          = pwm_n_r;
            assign timer_irq[g]          = irq_r;
            assign mode_select[g*4 +: 4] = mode_r;
        end
    endgenerate

endmodule

// *** verification/timer_pwm_regs_props.sv ***
/*
 * Port checker for timer_pwm_regs: bus handshakes, read data width,
 * mode select merge and PWM outputs never both high.
 * Assumes one clock core_clk and asynchronous active-high rst.
 */
`include "timer_pwm_defs.vh"
module timer_pwm_regs_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Timer side
    input wire logic [5:0]  mode_select_low,
    input wire logic [7:0]  mode_select,
    input wire logic [1:0]  pwm_out,
    input wire logic [1:0]  pwm_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_wr_resp; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no read response");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response unstable");
    property p_byte_wide; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("read data wider than a byte");
    property p_misalign; s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned read accepted");
    property p_mode; !$past(rst) |-> mode_select[2:0] == $past(mode_select_low[2:0])
        && mode_select[6:4] == $past(mode_select_low[5:3]); endproperty
    a_mode: assert property (p_mode) else $error("mode low bits not merged");
    property p_deadband; (pwm_out & pwm_out_n) == 2'h0; endproperty
    a_deadband: assert property (p_deadband) else $error("both outputs active");
endmodule
bind timer_pwm_regs timer_pwm_regs_chk chk_u (.*);

// *** verification/test_timer_pwm_regs.sv ***
/*
 * Self-checking bench for timer_pwm_regs: registers, capture, interrupt
 * source, PWM toggle and deadband.
 * Assumes the defines header and the bound port checker.
 */
`include "timer_pwm_defs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module test_timer_pwm_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, rst = 1;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, timer_count;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, timer_enable, capture_pulse, reload_pulse, output_polarity;
    logic [1:0]  pwm_out, pwm_out_n, timer_irq, ew, c;
    logic [5:0]  mode_select_low;
    logic [7:0]  mode_select, d;
    logic [33:0] rq[$], er;
    logic [1:0]  wq[$];
    logic [15:0] v;
    logic [2:0]  c3;
    logic        f;
    int          fail_count = 0, checked = 0, n, k, both, lo, ni;
    timer_pwm_regs dut_u (.*);
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] ad(input bit ch, input logic [11:0] idx);
        ad = {18'h0, idx + (ch ? `IDX_CH_STRIDE : 12'h0), 2'b00};
    endfunction
    task automatic end_sim;
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] dt, input logic [1:0] e);
        @(posedge core_clk);
        wq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, dt};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
            n++;
        end while (n < 60 && (s_axi_awvalid || s_axi_wvalid || s_axi_bready));
        if (n >= 60) fail_count++;
        if (n >= 60) end_sim;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] x, input logic [1:0] e);
        @(posedge core_clk);
        rq.push_back({e, 24'h0, x});
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b0;
            n++;
        end while (n < 60 && (s_axi_arvalid || s_axi_rready));
        if (n >= 60) fail_count++;
        if (n >= 60) end_sim;
    endtask
    // Response monitor
    always @(posedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready && wq.size() > 0) begin
            ew = wq.pop_front();
            `CHK(s_axi_bresp, ew)
        end
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            er = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
    end
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, timer_count} = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {timer_enable, capture_pulse, reload_pulse, output_polarity, mode_select_low} = 0;
        s_axi_wstrb = 4'h1;
        void'($urandom(96));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (k = 0; k < 6; k++) rd(ad(k / 3, `IDX_CMP_HIGH + 12'(k % 3)), `RST_CMP, `RESP_OKAY);
        for (k = 0; k < 6; k++) begin
            d = 8'($urandom);
            wr(ad(k / 3, `IDX_CMP_HIGH + 12'(k % 3)), d, `RESP_OKAY);
            rd(ad(k / 3, `IDX_CMP_HIGH + 12'(k % 3)), d & (k % 3 == 2 ? `CTL_WR_MASK : 8'hff), `RESP_OKAY);
        end
        rd(ad(0, `IDX_CTL_ZERO + 12'h1), 8'h00, `RESP_SLVERR);
        rd(ad(1, `IDX_CMP_HIGH) | 32'h2, 8'h00, `RESP_SLVERR);
        wr(ad(1, `IDX_CMP_LOW) | 32'h1, 8'h5a, `RESP_SLVERR);
        mode_select_low <= 6'($urandom);
        wr(ad(0, `IDX_CTL_ZERO), 8'h80, `RESP_OKAY);
        @(posedge core_clk);
        `CHK(mode_select[3:0], {1'b1, mode_select_low[2:0]})
        // Interrupt source codes against capture and reload
        for (k = 0; k < 6; k++) begin
            c = k < 2 ? 2'b00 : 2'(k / 2 + 1);
            wr(ad(1, `IDX_CTL_ZERO), {1'b0, c, 5'h0}, `RESP_OKAY);
            timer_count <= $urandom;
            capture_pulse[1] <= ~k[0];
            reload_pulse[1] <= k[0];
            @(posedge core_clk);
            {capture_pulse, reload_pulse} <= 4'h0;
            @(posedge core_clk);
            f = k < 2 || ((k < 4) == !k[0]);
            `CHK(timer_irq[1], f)
            rd(ad(1, `IDX_CTL_ZERO), {1'b0, c, 4'h0, f & !k[0]}, `RESP_OKAY);
            if (!k[0]) rd(ad(1, `IDX_CMP_HIGH), timer_count[31:24], `RESP_OKAY);
            if (!k[0]) rd(ad(1, `IDX_CMP_LOW), timer_count[23:16], `RESP_OKAY);
        end
        // Compare match with deadband codes 0, 2, 4, 7
        for (k = 0; k < 4; k++) begin
            c3 = 3'(k * 2 + k / 3);
            lo = c3 ? 1 << c3 : 0;
            v = 16'($urandom);
            output_polarity[0] <= k[0];
            timer_count[15:0] <= ~v;
            wr(ad(0, `IDX_CMP_HIGH), v[15:8], `RESP_OKAY);
            wr(ad(0, `IDX_CMP_LOW), v[7:0], `RESP_OKAY);
            wr(ad(0, `IDX_CTL_ZERO), {4'h0, c3, 1'b0}, `RESP_OKAY);
            repeat (140) @(posedge core_clk);
            `CHK(pwm_out[0], k[0])
            timer_enable[0] <= 1'b1;
            @(posedge core_clk);
            timer_count[15:0] <= v;
            @(posedge core_clk);
            timer_count[15:0] <= ~v;
            both = 0;
            ni = 0;
            repeat (140) @(posedge core_clk) begin
                both += int'((pwm_out[0] | pwm_out_n[0]) == 1'b0);
                ni += int'(timer_irq[0]);
            end
            `CHK(both >= lo && both <= lo + int'(c3 != 0), 1'b1)
            `CHK({pwm_out[0], pwm_out_n[0]}, {~k[0], k[0]})
            `CHK(ni, 1)
            timer_enable[0] <= 1'b0;
        end
        @(posedge core_clk);
        if (rq.size() + wq.size() != 0) fail_count++;
        end_sim;
    end
endmodule
